//--- include/wtb_pkg.sv
// Constants shared by the watch timer and buzzer block.
// Assumes a single 100 MHz clock; oscillators arrive as sampled levels.
package wtb_pkg;
   // Register map: one printed offset, taken as a byte address
   localparam logic [11:0] WTB_WMC_OFFSET = 12'h0F88;
   // Own status, mask, level and clear registers
   localparam logic [11:0] WTB_STAT_OFFSET = 12'h0F90;
   localparam logic [11:0] WTB_MASK_OFFSET = 12'h0F94;
   localparam logic [11:0] WTB_LVL_OFFSET  = 12'h0F98;
   localparam logic [11:0] WTB_CLR_OFFSET  = 12'h0F9C;
   // Mode register fields
   localparam int WTB_CSEL_BIT = 0;
   localparam int WTB_SPD_BIT  = 1;
   localparam int WTB_EN_BIT   = 2;
   localparam int WTB_LVL_BIT  = 3;
   localparam int WTB_BZF_LO   = 4;
   localparam int WTB_BZEN_BIT = 7;
   localparam logic [7:0] WTB_WMC_WMASK = 8'h00B7;
   localparam logic [7:0] WTB_WMC_RESET = 8'h0000;
   // Divider chain taps from the watch clock
   localparam int WTB_DIV_W     = 14;
   localparam int WTB_TAP_SLOW  = 13;
   localparam int WTB_TAP_FAST  = 6;
   localparam int WTB_BUZ_TAP0  = 3;
   localparam int WTB_MAIN_DIV  = 128;
   localparam int WTB_MAIN_DW   = 7;
   // Status bits
   localparam int WTB_ST_WIRQ = 0;
   localparam int WTB_ST_WAKE = 1;
   localparam int WTB_ST_W    = 2;
endpackage

//--- tb/tb.sv
// Bench for the watch timer: register tasks and one task per scenario.
// Assumes the oscillator model ticks the watch clock every 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
   logic        run = 0, lvl = 0, bclr = 1, stop = 0, latch = 0, dir = 1;
   logic        mosc = 0, mrun = 0;
   logic [11:0] addr_i = 12'h0000;
   logic [7:0]  wdata_i = 8'h00, rdata_o, d;
   logic        sub, buzzer_output, oe, lcd, flag, rel, irq;
   logic [15:0] edges;
   int          err_count = 0, checked = 0, n;
   wtb_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .main_osc_clock_i(mosc), .sub_osc_input_pin_i(sub),
      .main_stop_i(stop), .buzzer_latch_i(latch),
      .buzzer_pin_direction_flag_i(dir), .buzzer_output_o(buzzer_output),
      .buzzer_oe_o(oe), .lcd_clock_o(lcd), .watch_irq_flag_o(flag),
      .stop_release_o(rel), .irq_o(irq));
   wtb_osc_model osc (.clk_i(clk_i), .run_i(run), .level_i(lvl),
      .clr_i(bclr), .buzzer_output_i(buzzer_output), .buzzer_oe_i(oe),
      .sub_osc_o(sub), .buz_edges_o(edges));
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end
   // Main oscillator at half the bench clock while enabled
   always @(posedge clk_i)
   begin
      if (mrun)
         mosc <= ~mosc;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= v;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Counts cycles until the flag rises; a hang ends the run
   task automatic wait_flag();
      // Let a clear issued at this edge settle before looking
      #1;
      for (n = 0; flag !== 1'b1; n++)
      begin
         if (n > 40000)
         begin
            check("flag wait", 1, 0);
            final_report();
         end
         @(posedge clk_i);
         #1;
      end
   endtask
   task automatic t_reset();
      rd(12'h0F88);
      check("mode after reset", 8'h00, d);
      @(posedge clk_i);
      lvl <= 1'b1;
      repeat (4) @(posedge clk_i);
      rd(12'h0F88);
      check("level high", 8'h08, d);
      rd(12'h0F90);
      check("status idle", 8'h00, d);
      $display("reset test done");
   endtask
   task automatic t_start();
      @(posedge clk_i);
      run <= 1'b1;
      wr(12'h0F94, 8'h01);
      wr(12'h0F88, 8'h05);
      repeat (2) @(posedge clk_i);
      #1 check("flag at enable", 1, flag);
      check("irq unmasked", 1, irq);
      repeat (50) @(posedge clk_i);
      #1 check("flag sticky", 1, flag);
      wr(12'h0F9C, 8'h01);
      repeat (2) @(posedge clk_i);
      #1 check("flag cleared", 0, flag);
      rd(12'h0F90);
      check("status event", 8'h01, d);
      #1 check("irq after read", 0, irq);
      $display("start test done");
   endtask
   task automatic t_fast();
      @(posedge clk_i);
      stop <= 1'b1;
      wr(12'h0F88, 8'h07);
      repeat (2) @(posedge clk_i);
      wr(12'h0F9C, 8'h01);
      wait_flag();
      wr(12'h0F9C, 8'h01);
      wait_flag();
      // 2^7 ticks of 4 cycles, less the clear write
      check("fast period", 1, n >= 500 && n <= 516);
      check("stop release", 1, rel);
      rd(12'h0F90);
      check("wake status", 8'h03, d);
      @(posedge clk_i);
      stop <= 1'b0;
      $display("fast test done");
   endtask
   task automatic t_restart();
      wr(12'h0F88, 8'h00);
      wr(12'h0F9C, 8'h01);
      repeat (2) @(posedge clk_i);
      #1 check("flag off", 0, flag);
      wr(12'h0F88, 8'h05);
      repeat (2) @(posedge clk_i);
      #1 check("flag on restart", 1, flag);
      $display("restart test done");
   endtask
   task automatic t_buzz();
      for (int f = 0; f < 6; f++)
      begin
         @(posedge clk_i);
         dir <= (f != 4);
         latch <= (f == 5);
         wr(12'h0F88, 8'h85 | 8'((f & 3) << 4));
         repeat (8) @(posedge clk_i);
         bclr <= 1'b0;
         repeat (512) @(posedge clk_i);
         #1;
         if (f < 4)
            check("tone", 1, edges >= (8 << f) - 1 && edges <= (8 << f) + 1);
         else
            check("gated", 0, {edges[14:0], oe});
         bclr <= 1'b1;
      end
      $display("buzzer test done");
   endtask
   task automatic t_main();
      int   e;
      logic p;
      e = 0;
      p = 1'b0;
      wr(12'h0F88, 8'h00);
      @(posedge clk_i);
      mrun <= 1'b1;
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 1024; i++)
      begin
         @(posedge clk_i);
         #1;
         if (lcd && !p)
            e++;
         p = lcd;
      end
      check("lcd main", 1, e >= 3 && e <= 5);
      wr(12'h0F88, 8'h02);
      wr(12'h0F88, 8'h06);
      repeat (2) @(posedge clk_i);
      #1 check("flag main", 1, flag);
      wr(12'h0F9C, 8'h01);
      wait_flag();
      check("main period", 1, n >= 32400 && n <= 33100);
      @(posedge clk_i);
      mrun <= 1'b0;
      wr(12'h0F88, 8'h00);
      $display("main clock test done");
   endtask
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      bclr <= 1'b1;
      t_reset();
      t_start();
      t_fast();
      t_restart();
      t_buzz();
      t_main();
      final_report();
   end
endmodule // tb
`default_nettype wire

//--- tb/wtb_osc_model.sv
// Far side model: subsystem oscillator and buzzer listener.
// Assumes clk_i is the bench clock; the oscillator runs at clk/4.
`timescale 1ns/1ps
`default_nettype none
module wtb_osc_model
(
   input  wire logic        clk_i,
   input  wire logic        run_i,
   input  wire logic        level_i,
   input  wire logic        clr_i,
   input  wire logic        buzzer_output_i,
   input  wire logic        buzzer_oe_i,
   output logic             sub_osc_o,
   output logic      [15:0] buz_edges_o
);
   logic [1:0] div_r = 2'b00;
   logic       buz_r = 1'b0;
   // Fast oscillator keeps the long periods short in clock cycles
   always_ff @(posedge clk_i)
   begin
      div_r <= run_i ? div_r + 2'd1 : 2'd0;
      sub_osc_o <= run_i ? div_r[1] : level_i;
      buz_r <= buzzer_output_i & buzzer_oe_i;
      // Buzzer is only heard while the pin is driven
      if (clr_i)
         buz_edges_o <= 16'h0000;
      else if (buzzer_output_i & buzzer_oe_i & ~buz_r)
         buz_edges_o <= buz_edges_o + 16'h0001;
   end
endmodule // wtb_osc_model
`default_nettype wire

//--- verilog/wtb_divider.sv
// Frequency divider chain of the watch timer, stepped by watch clock ticks.
// Assumes tick_i is a one-cycle pulse per watch clock period.
`timescale 1ns/1ps
`default_nettype none
module wtb_divider
#(
   parameter int DIV_W = 14
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic             clr_i,
   input  wire logic             tick_i,
   output logic      [DIV_W-1:0] cnt_o
);
   typedef struct packed
   {
      logic [DIV_W-1:0] cnt;
   } wtb_div_type;
   wtb_div_type st_r;
   wtb_div_type st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      if (clr_i)
         st_nxt.cnt = '0;
      else if (tick_i)
         st_nxt.cnt = st_r.cnt + 1'b1;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_r <= '0;
      else if (ce_i)
         st_r <= st_nxt;
   end
   assign cnt_o = st_r.cnt;
endmodule // wtb_divider
`default_nettype wire

//--- verilog/wtb_sync.sv
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes clk_i is the system clock.
`timescale 1ns/1ps
`default_nettype none
module wtb_sync
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic d_i,
   output logic      q_o
);
   typedef struct packed
   {
      logic s1;
      logic s2;
   } wtb_sync_type;
   wtb_sync_type st_r;
   wtb_sync_type st_nxt;
   always_comb
   begin
      st_nxt = st_r;
      if (ce_i)
      begin
         st_nxt.s1 = d_i;
         st_nxt.s2 = st_r.s1;
      end
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end
   assign q_o = st_r.s2;
endmodule // wtb_sync
`default_nettype wire

//--- verilog/wtb_top.sv
// Watch timer with buzzer output and LCD clock source selection.
// Assumes oscillator levels and port bits arrive asynchronously.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module wtb_top
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic [11:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rdata_o,
   input  wire logic        main_osc_clock_i,
   input  wire logic        sub_osc_input_pin_i,
   input  wire logic        main_stop_i,
   input  wire logic        buzzer_latch_i,
   input  wire logic        buzzer_pin_direction_flag_i,
   output logic             buzzer_output_o,
   output logic             buzzer_oe_o,
   output logic             lcd_clock_o,
   output logic             watch_irq_flag_o,
   output logic             stop_release_o,
   output logic             irq_o
);
   localparam int DW = wtb_pkg::WTB_DIV_W;

   typedef struct packed
   {
      logic [7:0]               wmc;
      logic [6:0]               mdiv;
      logic                     main_d;
      logic                     sub_d;
      logic                     tick;
      logic                     first;
      logic                     wflag;
      logic [DW-1:0]            cnt_d;
      logic [wtb_pkg::WTB_ST_W-1:0] stat;
      logic [wtb_pkg::WTB_ST_W-1:0] mask;
      logic [7:0]               rdata;
      logic                     buzzer_output;
      logic                     boe;
      logic                     lcd;
   } wtb_top_type;

   wtb_top_type st_r;
   wtb_top_type st_nxt;

   logic          main_s;
   logic          sub_s;
   logic          lat_s;
   logic          dir_s;
   logic [DW-1:0] cnt;
   logic          div_clr;
   logic          tick_now;
   logic          main_edge;
   logic          sub_edge;
   logic          period_hit;
   logic          en;
   logic          wr_ev;
   logic          stat_rd;

   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      hit = (a == off);
   endfunction

   wtb_sync u_sync_main
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (main_osc_clock_i),
      .q_o   (main_s)
   );
   wtb_sync u_sync_sub
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (sub_osc_input_pin_i),
      .q_o   (sub_s)
   );
   wtb_sync u_sync_lat
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (buzzer_latch_i),
      .q_o   (lat_s)
   );
   wtb_sync u_sync_dir
   (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (buzzer_pin_direction_flag_i),
      .q_o   (dir_s)
   );

   wtb_divider #(.DIV_W(DW)) u_div
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .clr_i  (div_clr),
      .tick_i (tick_now),
      .cnt_o  (cnt)
   );

   assign en        = st_r.wmc[wtb_pkg::WTB_EN_BIT];
   assign div_clr   = ~en;
   assign main_edge = main_s & ~st_r.main_d;
   assign sub_edge  = sub_s & ~st_r.sub_d;
   // Main clock stops in stop mode, so its path produces no ticks then
   assign tick_now  = st_r.wmc[wtb_pkg::WTB_CSEL_BIT] ? sub_edge
                    : (main_edge && st_r.mdiv == 7'(wtb_pkg::WTB_MAIN_DIV-1)
                       && !main_stop_i);
   // Period hit on the divider carry out of the selected tap
   assign period_hit = st_r.wmc[wtb_pkg::WTB_SPD_BIT]
      // Falling edge, so the first fast period after enable is a full one
      ? (~cnt[wtb_pkg::WTB_TAP_FAST] & st_r.cnt_d[wtb_pkg::WTB_TAP_FAST])
      : (~cnt[wtb_pkg::WTB_TAP_SLOW] & st_r.cnt_d[wtb_pkg::WTB_TAP_SLOW]);
   assign wr_ev   = wr_i & hit(addr_i, wtb_pkg::WTB_WMC_OFFSET);
   assign stat_rd = rd_i & hit(addr_i, wtb_pkg::WTB_STAT_OFFSET);

   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.main_d = main_s;
      st_nxt.sub_d  = sub_s;
      st_nxt.cnt_d  = cnt;
      st_nxt.rdata  = 8'h0000;
      if (main_edge && !main_stop_i)
         st_nxt.mdiv = st_r.mdiv + 7'h0001;
      if (wr_ev)
         st_nxt.wmc = wdata_i & wtb_pkg::WTB_WMC_WMASK;
      // Start pulse on the enable rising edge
      st_nxt.first = wr_ev && !en && wdata_i[wtb_pkg::WTB_EN_BIT];
      if (wr_i && hit(addr_i, wtb_pkg::WTB_MASK_OFFSET))
         st_nxt.mask = wdata_i[wtb_pkg::WTB_ST_W-1:0];
      if (wr_i && hit(addr_i, wtb_pkg::WTB_CLR_OFFSET)
          && wdata_i[wtb_pkg::WTB_ST_WIRQ])
         st_nxt.wflag = 1'b0;
      if (stat_rd)
         st_nxt.stat = '0;
      // Set wins over clear for flag and status
      if (st_r.first || (en && period_hit))
      begin
         st_nxt.wflag = 1'b1;
         st_nxt.stat[wtb_pkg::WTB_ST_WIRQ] = 1'b1;
         if (main_stop_i)
            st_nxt.stat[wtb_pkg::WTB_ST_WAKE] = 1'b1;
      end
      if (rd_i)
      begin
         // Mode register itself is write only; bit 3 shows the pin
         if (hit(addr_i, wtb_pkg::WTB_WMC_OFFSET)
             || hit(addr_i, wtb_pkg::WTB_LVL_OFFSET))
            st_nxt.rdata[wtb_pkg::WTB_LVL_BIT] = sub_s;
         else if (hit(addr_i, wtb_pkg::WTB_STAT_OFFSET))
            st_nxt.rdata = {6'h00, st_r.stat};
         else if (hit(addr_i, wtb_pkg::WTB_MASK_OFFSET))
            st_nxt.rdata = {6'h00, st_r.mask};
         else if (hit(addr_i, wtb_pkg::WTB_CLR_OFFSET))
            st_nxt.rdata = {7'h00, st_r.wflag};
      end
      st_nxt.buzzer_output = cnt[wtb_pkg::WTB_BUZ_TAP0
                   - int'(st_r.wmc[wtb_pkg::WTB_BZF_LO +: 2])];
      st_nxt.boe = st_r.wmc[wtb_pkg::WTB_BZEN_BIT] & ~lat_s & dir_s;
      st_nxt.lcd = st_r.wmc[wtb_pkg::WTB_CSEL_BIT] ? sub_s
                   : st_r.mdiv[wtb_pkg::WTB_MAIN_DW-1];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r     <= '0;
         st_r.wmc <= wtb_pkg::WTB_WMC_RESET;
      end
      else if (ce_i)
         st_r <= st_nxt;
   end

   assign rdata_o          = st_r.rdata;
   assign buzzer_output_o  = st_r.buzzer_output & st_r.boe;
   assign buzzer_oe_o      = st_r.boe;
   assign lcd_clock_o      = st_r.lcd;
   assign watch_irq_flag_o = st_r.wflag;
   assign stop_release_o   = st_r.wflag & main_stop_i;
   assign irq_o            = |(st_r.stat & st_r.mask);

   AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.wflag && !(wr_i && hit(addr_i, wtb_pkg::WTB_CLR_OFFSET))
      |=> st_r.wflag)
      else $error("Watch flag dropped without a clear");
   AST_START_SET: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_ev && !en && wdata_i[wtb_pkg::WTB_EN_BIT] ##1 ce_i
      |=> st_r.wflag)
      else $error("Enable did not set the watch flag");
   AST_DIS_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !en |=> cnt == '0)
      else $error("Divider not cleared while disabled");
   AST_BUZ_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
      buzzer_output_o |-> st_r.wmc[wtb_pkg::WTB_BZEN_BIT])
      else $error("Buzzer active while disabled");
   AST_RD_LVL: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && rd_i && hit(addr_i, wtb_pkg::WTB_WMC_OFFSET)
      |=> rdata_o == {4'h0, $past(sub_s), 3'h0})
      else $error("Mode read must show only the level bit");
   AST_WR_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr_ev |=> st_r.wmc == ($past(wdata_i) & wtb_pkg::WTB_WMC_WMASK))
      else $error("Mode write not stored whole");
   AST_LCD_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && st_r.wmc[wtb_pkg::WTB_CSEL_BIT] && $stable(st_r.wmc)
      |=> lcd_clock_o == $past(sub_s))
      else $error("LCD clock not from subsystem clock");
   AST_STOP_REL: assert property (@(posedge clk_i) disable iff (rst_i)
      main_stop_i && watch_irq_flag_o |-> stop_release_o)
      else $error("Stop not released by watch flag");
endmodule // wtb_top
`default_nettype wire
